// file: hdl/tmcp_defines.vh
`ifndef TMCP_DEFINES_VH
`define TMCP_DEFINES_VH
// Register byte addresses
`define TMCP_A_CTRL1 8'h00
`define TMCP_A_CTRL2 8'h04
`define TMCP_A_STAT 8'h08
`define TMCP_A_IC1H 8'h0C
`define TMCP_A_IC1L 8'h10
`define TMCP_A_OC1H 8'h14
`define TMCP_A_OC1L 8'h18
`define TMCP_A_CNTH 8'h1C
`define TMCP_A_CNTL 8'h20
`define TMCP_A_IC2H 8'h24
`define TMCP_A_IC2L 8'h28
`define TMCP_A_OC2H 8'h2C
`define TMCP_A_OC2L 8'h30
// First control register fields
`define TMCP_C1_OLVL1 0
`define TMCP_C1_TRIGGER_EDGE_SELECT 1
`define TMCP_C1_OLVL2 2
`define TMCP_C1_FOLV1 3
`define TMCP_C1_FOLV2 4
`define TMCP_C1_TOIE 5
`define TMCP_C1_COMPARE_IRQ_ENABLE 6
`define TMCP_C1_CAPTURE_IRQ_ENABLE 7
`define TMCP_C1_FORCE_MASK 8'h18
// Second control register fields
`define TMCP_C2_EXEDG 0
`define TMCP_C2_IEDG2 1
`define TMCP_C2_CC_LO 2
`define TMCP_C2_CC_HI 3
`define TMCP_C2_PWM 4
`define TMCP_C2_OPM 5
`define TMCP_C2_OC2E 6
`define TMCP_C2_OC1E 7
// Flag vector positions, also status bits minus 3
`define TMCP_F_OCF2 0
`define TMCP_F_CAPTURE_FLAG_TWO 1
`define TMCP_F_TOF 2
`define TMCP_F_OCF1 3
`define TMCP_F_CAPTURE_FLAG_ONE 4
`define TMCP_STAT_SHIFT 3
// Clock select codes
`define TMCP_CC_DIV4 2'b00
`define TMCP_CC_DIV2 2'b01
`define TMCP_CC_DIV8 2'b10
`define TMCP_CC_EXT 2'b11
// Prescaler terminal counts
`define TMCP_LAST_DIV2 3'h1
`define TMCP_LAST_DIV4 3'h3
`define TMCP_LAST_DIV8 3'h7
// Reset and reload values
`define TMCP_OCR_RESET 16'h8000
`define TMCP_CNT_RELOAD 16'hFFFC
`define TMCP_CNT_TOP 16'hFFFF
`define TMCP_BYTE_RESET 8'h00
`define TMCP_WORD_ZERO 32'h0000_0000
`endif

// file: hdl/tmcp_sync3.v
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; output moves once stages two and three agree
module tmcp_sync3 #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Asynchronous levels and filtered result
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] level_o
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar g;

  // One chain per input bit
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
          stage3[g] <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          if (stage2[g] == stage3[g]) begin
            level_o[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate
endmodule // tmcp_sync3
`default_nettype wire

// file: hdl/tmcp_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "tmcp_defines.vh"
// Compare and one-pulse section of a 16-bit free-running timer
module tmcp_timer (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Timer pins in
  input wire capture_in_one_i,
  input wire capture_in_two_i,
  input wire ext_clk_i,
  // Compare pins out
  output wire [1:0] compare_out_pin_o,
  output wire [1:0] compare_out_oe_o,
  // Timer interrupt request level
  output wire timer_irq_o
);
  // Terminal prescaler count for a clock select code
  function [2:0] tmcp_div_last;
    input [1:0] cc;
    begin
      case (cc)
        `TMCP_CC_DIV2: tmcp_div_last = `TMCP_LAST_DIV2;
        `TMCP_CC_DIV8: tmcp_div_last = `TMCP_LAST_DIV8;
        default: tmcp_div_last = `TMCP_LAST_DIV4;
      endcase
    end
  endfunction

  // Address match used by every decode except the read data case
  function tmcp_hit;
    input [7:0] a;
    input [7:0] b;
    begin
      tmcp_hit = (a == b);
    end
  endfunction

  reg [7:0] timer_control_first;
  reg [7:0] timer_control_second;
  reg [15:0] cnt;
  reg [2:0] presc;
  reg cnt_chg;
  reg [15:0] capture_value_one;
  reg [15:0] capture_value_two;
  reg [1:0] cap_inh;
  reg [2:0] pin_prev;
  reg [4:0] flags;
  reg [4:0] arm;
  reg addr_ok;
  wire [2:0] pin_lvl;
  wire access;
  wire wr;
  wire rd;
  wire [1:0] clock_divide_field;
  wire ext_sel;
  wire ext_edge;
  wire tick;
  wire single_pulse_select;
  wire pwm_sel;
  wire opm_act;
  wire [1:0] cap_edge;
  wire trig;
  wire [1:0] cap_evt;
  wire [4:0] flag_set;
  wire [4:0] flag_clr_acc;
  wire [31:0] ocr_bus;
  wire [1:0] ocf_set;
  wire [1:0] compare_level_bit;
  wire [1:0] compare_pin_enable;
  wire [1:0] force_level_bit;
  wire wr_ctrl1;
  wire rd_stat;

  // APB handshake: zero wait states
  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign rd = access & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~addr_ok;
  assign wr_ctrl1 = wr & tmcp_hit(paddr_i, `TMCP_A_CTRL1);
  assign rd_stat = rd & tmcp_hit(paddr_i, `TMCP_A_STAT);

  // Control fields
  assign clock_divide_field = {timer_control_second[`TMCP_C2_CC_HI],
                               timer_control_second[`TMCP_C2_CC_LO]};
  assign ext_sel = (clock_divide_field == `TMCP_CC_EXT);
  assign single_pulse_select = timer_control_second[`TMCP_C2_OPM];
  assign pwm_sel = timer_control_second[`TMCP_C2_PWM];
  assign opm_act = single_pulse_select & ~pwm_sel;
  assign compare_level_bit = {timer_control_first[`TMCP_C1_OLVL2],
                              timer_control_first[`TMCP_C1_OLVL1]};
  assign compare_pin_enable = {timer_control_second[`TMCP_C2_OC2E],
                               timer_control_second[`TMCP_C2_OC1E]};
  assign force_level_bit = {pwdata_i[`TMCP_C1_FOLV2],
                            pwdata_i[`TMCP_C1_FOLV1]};

  // Control registers; force bits are write strobes only
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_control_first <= `TMCP_BYTE_RESET;
      timer_control_second <= `TMCP_BYTE_RESET;
    end else begin
      if (wr_ctrl1) begin
        timer_control_first <= pwdata_i[7:0] & ~`TMCP_C1_FORCE_MASK;
      end
      if (wr & tmcp_hit(paddr_i, `TMCP_A_CTRL2)) begin
        timer_control_second <= pwdata_i[7:0];
      end
    end
  end

  // Pin synchronisers: capture 1, capture 2, external clock
  tmcp_sync3 #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({ext_clk_i, capture_in_two_i, capture_in_one_i}),
    .level_o(pin_lvl)
  );

  // Previous filtered levels for edge detection
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_prev <= 3'b000;
    end else begin
      pin_prev <= pin_lvl;
    end
  end

  // Active edges chosen by edge select bits
  assign cap_edge[0] = (pin_lvl[0] != pin_prev[0]) &
    (pin_lvl[0] == timer_control_first[`TMCP_C1_TRIGGER_EDGE_SELECT]);
  assign cap_edge[1] = (pin_lvl[1] != pin_prev[1]) &
    (pin_lvl[1] == timer_control_second[`TMCP_C2_IEDG2]);
  assign ext_edge = (pin_lvl[2] != pin_prev[2]) &
    (pin_lvl[2] == timer_control_second[`TMCP_C2_EXEDG]);
  assign trig = opm_act & cap_edge[0];
  // Capture 1 disconnected in PWM mode; data held from high byte read until low byte read
  assign cap_evt[0] = cap_edge[0] & ~pwm_sel & ~cap_inh[0];
  assign cap_evt[1] = cap_edge[1] & ~cap_inh[1];

  // Timer tick: prescaled CPU clock or external edge
  assign tick = ext_sel ? ext_edge :
    (presc == tmcp_div_last(clock_divide_field));

  // Prescaler restarts with the counter on a trigger
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc <= 3'b000;
    end else if (trig | ext_sel | tick) begin
      presc <= 3'b000;
    end else begin
      presc <= presc + 3'b001;
    end
  end

  // Free-running counter with one-pulse reload
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= `TMCP_CNT_RELOAD;
      cnt_chg <= 1'b0;
    end else begin
      cnt_chg <= tick | trig;
      if (trig) begin
        cnt <= `TMCP_CNT_RELOAD;
      end else if (tick) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  // Capture registers and read interlock
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      capture_value_one <= 16'h0000;
      capture_value_two <= 16'h0000;
      cap_inh <= 2'b00;
    end else begin
      if (cap_evt[0]) begin
        capture_value_one <= cnt;
      end
      if (cap_evt[1]) begin
        capture_value_two <= cnt;
      end
      if (rd & tmcp_hit(paddr_i, `TMCP_A_IC1H)) begin
        cap_inh[0] <= 1'b1;
      end else if (rd & tmcp_hit(paddr_i, `TMCP_A_IC1L)) begin
        cap_inh[0] <= 1'b0;
      end
      if (rd & tmcp_hit(paddr_i, `TMCP_A_IC2H)) begin
        cap_inh[1] <= 1'b1;
      end else if (rd & tmcp_hit(paddr_i, `TMCP_A_IC2L)) begin
        cap_inh[1] <= 1'b0;
      end
    end
  end

  // Compare channels
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cmp
      reg [15:0] compare_value_reg;
      reg inhibit;
      reg pin_latch;
      wire match;
      wire hit_h;
      wire hit_l;
      wire in_opm_ch1;
      wire in_opm_ch2;
      assign hit_h = tmcp_hit(paddr_i, (g == 0) ? `TMCP_A_OC1H :
                                                   `TMCP_A_OC2H);
      assign hit_l = tmcp_hit(paddr_i, (g == 0) ? `TMCP_A_OC1L :
                                                   `TMCP_A_OC2L);
      assign in_opm_ch1 = opm_act & (g == 0);
      assign in_opm_ch2 = opm_act & (g == 1);
      // Match in the count where counter equals compare value
      assign match = cnt_chg & (cnt == compare_value_reg) &
        ~inhibit;
      // No flag from channel 1 in one-pulse, none at all in PWM
      assign ocf_set[g] = match & ~pwm_sel & ~in_opm_ch1;
      assign ocr_bus[g*16 +: 16] = compare_value_reg;
      assign compare_out_pin_o[g] = pin_latch;
      assign compare_out_oe_o[g] = compare_pin_enable[g];

      // Compare value and high-byte interlock
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          compare_value_reg <= `TMCP_OCR_RESET;
          inhibit <= 1'b0;
        end else if (wr & hit_h) begin
          compare_value_reg[15:8] <= pwdata_i[7:0];
          inhibit <= 1'b1;
        end else if (wr & hit_l) begin
          compare_value_reg[7:0] <= pwdata_i[7:0];
          inhibit <= 1'b0;
        end
      end

      // Pin latch: trigger, match, or software force
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pin_latch <= 1'b0;
        end else if (in_opm_ch1 & trig) begin
          pin_latch <= compare_level_bit[1];
        end else if (match & compare_pin_enable[g] & ~in_opm_ch2) begin
          pin_latch <= compare_level_bit[g];
        end else if (wr_ctrl1 & force_level_bit[g] & ~opm_act & ~pwm_sel &
                     compare_pin_enable[g]) begin
          pin_latch <= pwdata_i[g == 0 ? `TMCP_C1_OLVL1 :
                                `TMCP_C1_OLVL2];
        end
      end
    end
  endgenerate

  // Flag set sources and clearing accesses
  assign flag_set[`TMCP_F_OCF2] = ocf_set[1];
  assign flag_set[`TMCP_F_CAPTURE_FLAG_TWO] = cap_evt[1];
  assign flag_set[`TMCP_F_TOF] = tick & (cnt == `TMCP_CNT_TOP);
  assign flag_set[`TMCP_F_OCF1] = ocf_set[0];
  assign flag_set[`TMCP_F_CAPTURE_FLAG_ONE] = cap_evt[0];
  assign flag_clr_acc[`TMCP_F_OCF2] = access &
    tmcp_hit(paddr_i, `TMCP_A_OC2L);
  assign flag_clr_acc[`TMCP_F_CAPTURE_FLAG_TWO] = access &
    tmcp_hit(paddr_i, `TMCP_A_IC2L);
  assign flag_clr_acc[`TMCP_F_TOF] = access &
    tmcp_hit(paddr_i, `TMCP_A_CNTL);
  assign flag_clr_acc[`TMCP_F_OCF1] = access &
    tmcp_hit(paddr_i, `TMCP_A_OC1L);
  assign flag_clr_acc[`TMCP_F_CAPTURE_FLAG_ONE] = access &
    tmcp_hit(paddr_i, `TMCP_A_IC1L);

  // Two-step clearing per flag; a new set wins over a clear
  genvar f;
  generate
    for (f = 0; f < 5; f = f + 1) begin : g_flag
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          flags[f] <= 1'b0;
          arm[f] <= 1'b0;
        end else begin
          if (flag_set[f]) begin
            flags[f] <= 1'b1;
          end else if (arm[f] & flag_clr_acc[f]) begin
            flags[f] <= 1'b0;
          end
          if (rd_stat) begin
            arm[f] <= flags[f];
          end else if (flag_clr_acc[f]) begin
            arm[f] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Interrupt request from enabled flags
  assign timer_irq_o =
    (timer_control_first[`TMCP_C1_CAPTURE_IRQ_ENABLE] &
     (flags[`TMCP_F_CAPTURE_FLAG_ONE] | flags[`TMCP_F_CAPTURE_FLAG_TWO])) |
    (timer_control_first[`TMCP_C1_COMPARE_IRQ_ENABLE] &
     (flags[`TMCP_F_OCF1] | flags[`TMCP_F_OCF2])) |
    (timer_control_first[`TMCP_C1_TOIE] & flags[`TMCP_F_TOF]);

  // Read data registered in the setup cycle
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= `TMCP_WORD_ZERO;
      addr_ok <= 1'b0;
    end else if (psel_i & ~penable_i) begin
      addr_ok <= 1'b1;
      prdata_o <= `TMCP_WORD_ZERO;
      case (paddr_i)
        `TMCP_A_CTRL1: prdata_o[7:0] <= timer_control_first;
        `TMCP_A_CTRL2: prdata_o[7:0] <= timer_control_second;
        `TMCP_A_STAT: prdata_o[7:0] <= {flags, 3'b000};
        `TMCP_A_IC1H: prdata_o[7:0] <= capture_value_one[15:8];
        `TMCP_A_IC1L: prdata_o[7:0] <= capture_value_one[7:0];
        `TMCP_A_OC1H: prdata_o[7:0] <= ocr_bus[15:8];
        `TMCP_A_OC1L: prdata_o[7:0] <= ocr_bus[7:0];
        `TMCP_A_CNTH: prdata_o[7:0] <= cnt[15:8];
        `TMCP_A_CNTL: prdata_o[7:0] <= cnt[7:0];
        `TMCP_A_IC2H: prdata_o[7:0] <= capture_value_two[15:8];
        `TMCP_A_IC2L: prdata_o[7:0] <= capture_value_two[7:0];
        `TMCP_A_OC2H: prdata_o[7:0] <= ocr_bus[31:24];
        `TMCP_A_OC2L: prdata_o[7:0] <= ocr_bus[23:16];
        default: addr_ok <= 1'b0;
      endcase
    end
  end
endmodule // tmcp_timer
`default_nettype wire

// file: bench/tmcp_timer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmcp_defines.vh"
module tmcp_timer_checker (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Register bus
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Timer pins
  input wire capture_in_one_i,
  input wire capture_in_two_i,
  input wire ext_clk_i,
  input wire [1:0] compare_out_pin_o,
  input wire [1:0] compare_out_oe_o,
  input wire timer_irq_o
);
  logic [7:0] c1;
  logic [7:0] c2;
  logic [15:0] oc1;
  int pcnt;
  wire wacc = psel_i && penable_i && pwrite_i && pready_o;
  wire pulse_mode = c2[5] && !c2[4];
  wire [19:0] plen = ({4'h0, oc1} + 20'd5) * 20'd4;
  // Shadows of control and compare 1 writes, pulse length counter
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c1 <= 8'h00;
      c2 <= 8'h00;
      oc1 <= 16'h8000;
      pcnt <= 0;
    end else begin
      if (wacc && paddr_i == `TMCP_A_CTRL1) c1 <= pwdata_i[7:0];
      if (wacc && paddr_i == `TMCP_A_CTRL2) c2 <= pwdata_i[7:0];
      if (wacc && paddr_i == `TMCP_A_OC1H) oc1[15:8] <= pwdata_i[7:0];
      if (wacc && paddr_i == `TMCP_A_OC1L) oc1[7:0] <= pwdata_i[7:0];
      pcnt <= compare_out_pin_o[0] ? pcnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_pin_reset_low: assert property (disable iff (1'b0)
    !rst_b_i ##1 !rst_b_i |-> compare_out_pin_o == 2'b00)
    else $error("compare pins not low in reset");
  a_oe_follow_ctrl: assert property (wacc && paddr_i == `TMCP_A_CTRL2
    |=> compare_out_oe_o == {$past(pwdata_i[6]), $past(pwdata_i[7])})
    else $error("pin enables differ from written control");
  a_oe_clear_hold: assert property (!compare_out_oe_o[1]
    && !$past(compare_out_oe_o[1]) |-> $stable(compare_out_pin_o[1]))
    else $error("disabled compare pin changed");
  a_force_copy_level: assert property (wacc && paddr_i == `TMCP_A_CTRL1
    && pwdata_i[3] && !c2[5] && !c2[4] && compare_out_oe_o[0]
    |=> compare_out_pin_o[0] == $past(pwdata_i[0]))
    else $error("forced level not copied to pin");
  a_ch2_pulse_still: assert property (pulse_mode && $past(pulse_mode)
    |-> $stable(compare_out_pin_o[1]))
    else $error("channel 2 pin moved in one-pulse mode");
  a_trigger_drives: assert property ($rose(capture_in_one_i) && c1[1]
    && pulse_mode && compare_out_oe_o[0]
    |-> ##[1:10] compare_out_pin_o[0] == c1[2])
    else $error("trigger did not drive pulse level");
  a_pulse_length: assert property ($fell(compare_out_pin_o[0])
    && pulse_mode && c2[3:2] == 2'b00 |-> pcnt >= plen - 4 && pcnt <= plen + 4)
    else $error("pulse length off");
  a_irq_enabled: assert property (timer_irq_o |-> c1[7:5] != 3'b000
    || $past(c1[7:5]) != 3'b000)
    else $error("interrupt with no enable set");
  cover property ($fell(compare_out_pin_o[0]) && pulse_mode);
  cover property ($rose(compare_out_pin_o[1]));
  cover property (wacc && paddr_i == `TMCP_A_CTRL1 && pwdata_i[3]);
endmodule // tmcp_timer_checker
bind tmcp_timer tmcp_timer_checker u_tmcp_timer_checker (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .capture_in_one_i(capture_in_one_i), .capture_in_two_i(capture_in_two_i),
  .ext_clk_i(ext_clk_i), .compare_out_pin_o(compare_out_pin_o),
  .compare_out_oe_o(compare_out_oe_o), .timer_irq_o(timer_irq_o)
);
`default_nettype wire

// file: bench/test_timer_compare_one_pulse.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmcp_defines.vh"
module test_timer_compare_one_pulse;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic capture_in_one_i = 1'b0;
  logic capture_in_two_i = 1'b0;
  logic ext_clk_i = 1'b0;
  wire [31:0] prdata_o;
  wire pready_o;
  wire pslverr_o;
  wire [1:0] compare_out_pin_o;
  wire [1:0] compare_out_oe_o;
  wire timer_irq_o;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int dur;
  logic [7:0] rdat;
  logic rerr;
  logic [7:0] cnt_first;
  logic [7:0] cnt_diff;
  // 125 MHz clock
  always #4 clk_i = ~clk_i;
  tmcp_timer u_tmcp_timer (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .capture_in_one_i(capture_in_one_i), .capture_in_two_i(capture_in_two_i),
    .ext_clk_i(ext_clk_i), .compare_out_pin_o(compare_out_pin_o),
    .compare_out_oe_o(compare_out_oe_o), .timer_irq_o(timer_irq_o)
  );
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h00_0000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o[7:0];
    rerr = pslverr_o;
    chk("read upper bits", {8'h00, prdata_o[31:8]}, 32'h0000_0000);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rdat, e);
  endtask
  // Bounded wait for a compare pin level
  task automatic wait_pin(input int b, input logic v);
    int n;
    n = 0;
    while (compare_out_pin_o[b] !== v && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk("pin wait", n < 1000, 32'd1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(`TMCP_A_OC1H, 8'h80, "cmp1 high reset");
    rd(`TMCP_A_OC1L, 8'h00, "cmp1 low reset");
    rd(`TMCP_A_OC2H, 8'h80, "cmp2 high reset");
    chk("pins reset", compare_out_pin_o, 32'd0);
    apb(1'b0, 8'h34, 8'h00);
    chk("unmapped error", rerr, 32'd1);
    chk("unmapped data", rdat, 32'd0);
    wr(`TMCP_A_CTRL2, 8'hC0);
    wr(`TMCP_A_CTRL1, 8'h0D);
    // Overflow flag already set by the FFFCh start count
    rd(`TMCP_A_STAT, 8'h20, "status");
    chk("pin enables", compare_out_oe_o, 32'd3);
    chk("forced high", compare_out_pin_o[0], 32'd1);
    chk("force sets no flag", rdat[6], 32'd0);
    wr(`TMCP_A_CTRL1, 8'h0C);
    // Compare 2 at 0060h, suspended until its low byte is written
    wr(`TMCP_A_OC2L, 8'h60);
    wr(`TMCP_A_OC2H, 8'h00);
    chk("forced low", compare_out_pin_o[0], 32'd0);
    // Counter passes 0060h while the channel is suspended
    repeat (500) @(posedge clk_i);
    rd(`TMCP_A_STAT, 8'h20, "status");
    chk("suspended compare", rdat[3], 32'd0);
    chk("suspended pin", compare_out_pin_o[1], 32'd0);
    wr(`TMCP_A_OC2L, 8'hC0);
    wait_pin(1, 1'b1);
    rd(`TMCP_A_STAT, 8'h28, "status");
    chk("match flag", rdat[3], 32'd1);
    chk("no irq unenabled", timer_irq_o, 32'd0);
    rd(`TMCP_A_OC2L, 8'hC0, "cmp2 low readback");
    rd(`TMCP_A_STAT, 8'h20, "status");
    chk("flag cleared", rdat[3], 32'd0);
    wr(`TMCP_A_OC1H, 8'h00);
    wr(`TMCP_A_OC1L, 8'h10);
    wr(`TMCP_A_CTRL1, 8'h86);
    wr(`TMCP_A_CTRL2, 8'hE0);
    capture_in_one_i <= 1'b1;
    wait_pin(0, 1'b1);
    dur = 0;
    while (compare_out_pin_o[0] !== 1'b0 && dur < 500) begin
      @(posedge clk_i);
      dur++;
    end
    chk("pulse length", dur >= 80 && dur <= 88, 32'd1);
    rd(`TMCP_A_STAT, 8'hA0, "status");
    chk("trigger flags", rdat[7:6], 32'd2);
    chk("trigger irq", timer_irq_o, 32'd1);
    wr(`TMCP_A_CTRL1, 8'h8F);
    repeat (2) @(posedge clk_i);
    chk("force in pulse mode", compare_out_pin_o[0], 32'd0);
    wr(`TMCP_A_CTRL1, 8'h86);
    capture_in_two_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    capture_in_two_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(`TMCP_A_STAT, 8'hB0, "status");
    chk("capture two flag", rdat[4], 32'd1);
    // Divide by 8: reads 83 clocks apart see 10 or 11 counts
    wr(`TMCP_A_CTRL2, 8'h08);
    apb(1'b0, `TMCP_A_CNTL, 8'h00);
    cnt_first = rdat;
    repeat (80) @(posedge clk_i);
    apb(1'b0, `TMCP_A_CNTL, 8'h00);
    cnt_diff = rdat - cnt_first;
    chk("div8 rate", cnt_diff == 8'h0A || cnt_diff == 8'h0B, 32'd1);
    // External clock: six rising edges give six counts
    wr(`TMCP_A_CTRL2, 8'h0D);
    apb(1'b0, `TMCP_A_CNTL, 8'h00);
    cnt_first = rdat;
    repeat (6) begin
      ext_clk_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      ext_clk_i <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    apb(1'b0, `TMCP_A_CNTL, 8'h00);
    cnt_diff = rdat - cnt_first;
    chk("ext edge count", cnt_diff, 32'd6);
    end_sim;
  end
endmodule // test_timer_compare_one_pulse
`default_nettype wire
